// File: pio_port_bank.sv
// Parallel I/O port bank with an AXI4-Lite register slave.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pio_params.svh"
module pio_port_bank
(
  input wire logic aclk, // Bus clock, 250 MHz.
  input wire logic aresetn, // System reset, synchronous, low.
  input wire logic power_on_rst, // Power-on or low-voltage reset, high.
  input wire pio_pkg::pio_axi_req_s axi_req, // AXI4-Lite master signals.
  output pio_pkg::pio_axi_rsp_s axi_rsp, // AXI4-Lite slave signals.
  input wire pio_pkg::pio_pins_s pins_i, // Pin levels.
  output pio_pkg::pio_pins_s pins_o, // Pin output values.
  output pio_pkg::pio_pins_s pins_oe, // Pin output enables.
  output pio_pkg::pio_pins_s pullup_en, // Internal pullup enables.
  output logic [2:0] led_drive, // LED drive on port B pins.
  output logic dp_pullup_en, // Data-plus pullup option.
  output logic [7:0] key_wake_inputs // Enabled key inputs to interrupt unit.
);
  import pio_pkg::*;

  pio_state_s s_q;
  pio_state_s s_d;

  // Implemented bits of each port's data and direction registers.
  function automatic logic [7:0] port_mask(input int p);
    logic [7:0] m;
    m = `PIO_MASK_A;
    unique case (p)
      `PIO_PORT_B: m = `PIO_MASK_B;
      `PIO_PORT_C: m = `PIO_MASK_C;
      `PIO_PORT_D: m = `PIO_MASK_D;
      `PIO_PORT_E: m = `PIO_MASK_E;
      default: m = `PIO_MASK_A;
    endcase
    return m;
  endfunction : port_mask

  // Spreads the 29 pins over five 8-bit port images.
  function automatic pio_bank_t pins_to_bank(input pio_pins_s v);
    pio_bank_t b;
    b = '0;
    b[`PIO_PORT_A] = v.a;
    b[`PIO_PORT_B] = {2'h0, v.b[2], 3'h0, v.b[1:0]};
    b[`PIO_PORT_C] = {4'h0, v.c};
    b[`PIO_PORT_D] = v.d;
    b[`PIO_PORT_E] = {v.e, 2'h0};
    return b;
  endfunction : pins_to_bank

  // Gathers the 29 pins back from five 8-bit port images.
  function automatic pio_pins_s bank_to_pins(input pio_bank_t b);
    pio_pins_s v;
    v.a = b[`PIO_PORT_A];
    v.b = {b[`PIO_PORT_B][5], b[`PIO_PORT_B][1:0]};
    v.c = b[`PIO_PORT_C][3:0];
    v.d = b[`PIO_PORT_D];
    v.e = b[`PIO_PORT_E][7:2];
    return v;
  endfunction : bank_to_pins

  // Register kind at a word address.
  function automatic pio_reg_e reg_kind(input logic [`PIO_AXI_AW-1:0] addr);
    logic [`PIO_IDX_BITS-1:0] idx;
    pio_reg_e k;
    idx = addr[`PIO_IDX_BITS+1:2];
    k = PIO_REG_NONE;
    if (addr[1:0] == 2'h0 && addr[`PIO_AXI_AW-1:`PIO_IDX_BITS+2] == '0)
    begin
      unique case (idx)
        `PIO_IDX_DATA_A, `PIO_IDX_DATA_B, `PIO_IDX_DATA_C,
        `PIO_IDX_DATA_D, `PIO_IDX_DATA_E: k = PIO_REG_DATA;
        `PIO_IDX_DIR_A, `PIO_IDX_DIR_B, `PIO_IDX_DIR_C,
        `PIO_IDX_DIR_D, `PIO_IDX_DIR_E: k = PIO_REG_DIR;
        `PIO_IDX_KEY_IRQ: k = PIO_REG_KEY;
        `PIO_IDX_OPT_ONE: k = PIO_REG_OPT1;
        `PIO_IDX_OPT_TWO: k = PIO_REG_OPT2;
        `PIO_IDX_PULLUP: k = PIO_REG_PULL;
        default: k = PIO_REG_NONE;
      endcase
    end
    return k;
  endfunction : reg_kind

  // Port number of a data or direction register.
  function automatic int reg_port(input logic [`PIO_AXI_AW-1:0] addr);
    logic [`PIO_IDX_BITS-1:0] idx;
    int p;
    idx = addr[`PIO_IDX_BITS+1:2];
    p = `PIO_PORT_A;
    unique case (idx)
      `PIO_IDX_DATA_B, `PIO_IDX_DIR_B: p = `PIO_PORT_B;
      `PIO_IDX_DATA_C, `PIO_IDX_DIR_C: p = `PIO_PORT_C;
      `PIO_IDX_DATA_D, `PIO_IDX_DIR_D: p = `PIO_PORT_D;
      `PIO_IDX_DATA_E, `PIO_IDX_DIR_E: p = `PIO_PORT_E;
      default: p = `PIO_PORT_A;
    endcase
    return p;
  endfunction : reg_port

  pio_bank_t pin_bank;
  pio_bank_t read_bank;
  pio_pins_s pull_other;

  assign pin_bank = pins_to_bank(s_q.sync2);

  // Output pins show the latch, input pins show the synchronised level.
  genvar gp;
  generate
    for (gp = 0; gp < `PIO_NPORTS; gp++)
    begin : g_port
      assign read_bank[gp] = ((s_q.dir[gp] & s_q.lat[gp]) | (~s_q.dir[gp] & pin_bank[gp]))
                             & port_mask(gp); // [RULE13]
    end
  endgenerate

  // Pullups on port B come from the pullup register, on ports D and E from option register two.
  always_comb
  begin
    pull_other = '0;
    pull_other.b = {s_q.pull[`PIO_B_TOP], s_q.pull[`PIO_B_LOW_TOP:0]};
    pull_other.d[`PIO_D_PULL_HI] = s_q.opt2[`PIO_OPT2_PULL_D7];
    pull_other.d[`PIO_D_PULL_MID] = s_q.opt2[`PIO_OPT2_PULL_D3];
    pull_other.d[`PIO_D_PULL_LO] = s_q.opt2[`PIO_OPT2_PULL_D2];
    pull_other.e[`PIO_E_SLOT_3] = s_q.opt2[`PIO_OPT2_PULL_E3];
    pull_other.e[`PIO_E_SLOT_2] = s_q.opt2[`PIO_OPT2_PULL_E2];
  end

  always_comb
  begin
    pio_reg_e wk;
    pio_reg_e rk;
    int wp;
    int rp;
    logic [7:0] bit7;
    s_d = s_q;
    wk = reg_kind(s_q.awaddr);
    wp = reg_port(s_q.awaddr);
    rk = reg_kind(axi_req.araddr);
    rp = reg_port(axi_req.araddr);
    bit7 = 8'h00;
    s_d.sync1 = pins_i;
    s_d.sync2 = s_q.sync1;
    if (axi_req.awvalid && !s_q.aw_got)
    begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_q.w_got)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_req.wdata[7:0];
      s_d.wlane0 = axi_req.wstrb[0];
    end
    if (s_q.bvalid && axi_req.bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = (wk == PIO_REG_NONE) ? `PIO_RESP_SLVERR : `PIO_RESP_OKAY;
      if (s_q.wlane0)
      begin
        unique case (wk)
          PIO_REG_DATA: s_d.lat[wp] = s_q.wdata & port_mask(wp); // [RULE3] [RULE14] [RULE15]
          PIO_REG_DIR: s_d.dir[wp] = s_q.wdata & port_mask(wp); // [RULE5] [RULE9] [RULE10] [RULE11] [RULE15]
          PIO_REG_KEY: s_d.key_en = s_q.wdata & `PIO_MASK_KEY_IRQ;
          PIO_REG_OPT1: s_d.opt1 = s_q.wdata & `PIO_MASK_OPT_ONE; // [RULE15]
          PIO_REG_OPT2: s_d.opt2 = s_q.wdata & `PIO_MASK_OPT_TWO; // [RULE15]
          PIO_REG_PULL: s_d.pull = s_q.wdata & `PIO_MASK_PULLUP; // [RULE15]
          default: s_d.bresp = `PIO_RESP_SLVERR;
        endcase
      end
    end
    if (s_q.rvalid && axi_req.rready)
    begin
      s_d.rvalid = 1'b0;
    end
    else if (axi_req.arvalid && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `PIO_RESP_OKAY;
      unique case (rk)
        PIO_REG_DATA: s_d.rdata = read_bank[rp]; // [RULE13]
        PIO_REG_DIR: s_d.rdata = s_q.dir[rp] & port_mask(rp); // [RULE15]
        PIO_REG_KEY: s_d.rdata = s_q.key_en;
        PIO_REG_OPT1: s_d.rdata = s_q.opt1;
        PIO_REG_OPT2: s_d.rdata = s_q.opt2;
        PIO_REG_PULL: s_d.rdata = s_q.pull;
        default:
        begin
          s_d.rdata = `PIO_RST_VAL;
          s_d.rresp = `PIO_RESP_SLVERR;
        end
      endcase
    end
    if (!aresetn)
    begin
      // System reset spares the output latches and direction bit 7 of port A.
      bit7 = {s_q.dir[`PIO_PORT_A][`PIO_DIR_A_BIT7], 7'h00};
      s_d = '0;
      s_d.lat = s_q.lat; // [RULE4]
      s_d.dir[`PIO_PORT_A] = bit7; // [RULE7] [RULE12]
    end
    if (power_on_rst)
    begin
      s_d.dir[`PIO_PORT_A][`PIO_DIR_A_BIT7] = 1'b0; // [RULE7]
    end
  end

  always_ff @(posedge aclk)
  begin
    s_q <= s_d;
  end

  always_comb
  begin
    axi_rsp.awready = !s_q.aw_got;
    axi_rsp.wready = !s_q.w_got;
    axi_rsp.bvalid = s_q.bvalid;
    axi_rsp.bresp = s_q.bresp;
    axi_rsp.arready = !s_q.rvalid;
    axi_rsp.rvalid = s_q.rvalid;
    axi_rsp.rdata = {24'h000000, s_q.rdata};
    axi_rsp.rresp = s_q.rresp;
  end

  assign pins_o = bank_to_pins(s_q.lat); // [RULE1] [RULE2]
  assign pins_oe = bank_to_pins(s_q.dir); // [RULE6]
  assign key_wake_inputs = s_q.sync2.a & s_q.key_en; // [RULE8]
  assign led_drive = {s_q.opt1[`PIO_B_TOP], s_q.opt1[`PIO_B_LOW_TOP:0]};
  assign dp_pullup_en = s_q.opt2[`PIO_OPT2_USB_PULL];

  always_comb
  begin
    pullup_en = pull_other;
    pullup_en.a = s_q.key_en; // [RULE8]
  end

endmodule : pio_port_bank

// File: pio_params.svh
// Constants for the parallel I/O port bank.
// Behaviour
// [RULE1] Twenty-nine pins in five ports, each configurable.
// [RULE2] Port A: eight pins, shared with keyboard unit.
// [RULE3] Port A holds eight writable output latches.
// [RULE4] Reset leaves port A latches unchanged.
// [RULE5] Port A direction bit steers same pin.
// [RULE6] Direction one drives pin, zero makes input.
// [RULE7] Port A direction bit 7 kept except power-on.
// [RULE8] Key enable makes pin interrupt input with pullup.
// [RULE9] Port C direction at 0x0006, bits 3:0, reset zero.
// [RULE10] Port D direction at 0x0007, eight bits, reset zero.
// [RULE11] Port E direction at 0x0009, bits 7:2, reset zero.
// [RULE12] Reset clears port A direction bits; system reset here clears bits 6:0 and keeps bit 7.
// [RULE13] Data read: latch for outputs, pin for inputs.
// [RULE14] Output latches accept writes in any direction.
// [RULE15] Unimplemented control bits ignore writes, read zero.
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH
`define PIO_AXI_AW 12
`define PIO_IDX_BITS 8
`define PIO_IDX_DATA_A 8'h00
`define PIO_IDX_DATA_B 8'h01
`define PIO_IDX_DATA_C 8'h02
`define PIO_IDX_DATA_D 8'h03
`define PIO_IDX_DIR_A 8'h04
`define PIO_IDX_DIR_B 8'h05
`define PIO_IDX_DIR_C 8'h06
`define PIO_IDX_DIR_D 8'h07
`define PIO_IDX_DATA_E 8'h08
`define PIO_IDX_DIR_E 8'h09
`define PIO_IDX_KEY_IRQ 8'h17
`define PIO_IDX_OPT_ONE 8'h1A
`define PIO_IDX_OPT_TWO 8'h1B
`define PIO_IDX_PULLUP 8'h3E
`define PIO_MASK_A 8'hFF
`define PIO_MASK_B 8'h23
`define PIO_MASK_C 8'h0F
`define PIO_MASK_D 8'hFF
`define PIO_MASK_E 8'hFC
`define PIO_MASK_OPT_ONE 8'h23
`define PIO_MASK_OPT_TWO 8'h3F
`define PIO_MASK_PULLUP 8'h23
`define PIO_MASK_KEY_IRQ 8'hFF
`define PIO_RST_VAL 8'h00
`define PIO_DIR_A_BIT7 7
`define PIO_PORT_A 0
`define PIO_PORT_B 1
`define PIO_PORT_C 2
`define PIO_PORT_D 3
`define PIO_PORT_E 4
`define PIO_NPORTS 5
`define PIO_OPT2_PULL_D7 5
`define PIO_OPT2_PULL_D3 4
`define PIO_OPT2_PULL_D2 3
`define PIO_OPT2_USB_PULL 2
`define PIO_OPT2_PULL_E3 1
`define PIO_OPT2_PULL_E2 0
`define PIO_B_TOP 5
`define PIO_B_LOW_TOP 1
`define PIO_D_PULL_HI 7
`define PIO_D_PULL_MID 3
`define PIO_D_PULL_LO 2
`define PIO_E_SLOT_3 1
`define PIO_E_SLOT_2 0
`define PIO_RESP_OKAY 2'h0
`define PIO_RESP_SLVERR 2'h2
`endif

// File: pio_pkg.sv
// Types shared by the parallel I/O port bank.
`include "pio_params.svh"
package pio_pkg;

  typedef struct packed {
    logic [5:0] e;
    logic [7:0] d;
    logic [3:0] c;
    logic [2:0] b;
    logic [7:0] a;
  } pio_pins_s;

  typedef logic [`PIO_NPORTS-1:0][7:0] pio_bank_t;

  typedef struct packed {
    logic awvalid;
    logic [`PIO_AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`PIO_AXI_AW-1:0] araddr;
    logic rready;
  } pio_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pio_axi_rsp_s;

  typedef enum logic [3:0] {
    PIO_REG_NONE, PIO_REG_DATA, PIO_REG_DIR, PIO_REG_KEY,
    PIO_REG_OPT1, PIO_REG_OPT2, PIO_REG_PULL
  } pio_reg_e;

  typedef struct packed {
    pio_bank_t lat;
    pio_bank_t dir;
    logic [7:0] key_en;
    logic [7:0] opt1;
    logic [7:0] opt2;
    logic [7:0] pull;
    pio_pins_s sync1;
    pio_pins_s sync2;
    logic aw_got;
    logic [`PIO_AXI_AW-1:0] awaddr;
    logic w_got;
    logic [7:0] wdata;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } pio_state_s;

endpackage : pio_pkg

// File: pio_pins_model.sv
// Pin model for the far side of the port bank.
`timescale 1ns/1ps
module pio_pins_model
(
  input wire pio_pkg::pio_pins_s pins_o, // Bank output values.
  input wire pio_pkg::pio_pins_s pins_oe, // Bank drive enables.
  input wire pio_pkg::pio_pins_s pullup_en, // Bank pullups.
  input wire pio_pkg::pio_pins_s ext, // Outside driver levels.
  output pio_pkg::pio_pins_s pins_i // Resolved pin levels.
);
  import pio_pkg::*;
  // An undriven pin follows the outside driver, lifted to one where pulled up.
  assign pins_i = (pins_oe & pins_o) | (~pins_oe & (ext | pullup_en));
endmodule : pio_pins_model

// File: pio_port_bank_checker.sv
// Assertions on the ports of the parallel I/O port bank.
`timescale 1ns/1ps
`include "pio_params.svh"
module pio_port_bank_checker
(
  input wire logic aclk, // Bus clock.
  input wire logic aresetn, // System reset, low.
  input wire logic power_on_rst, // Power-on reset.
  input wire pio_pkg::pio_axi_req_s axi_req, // Bus requests.
  input wire pio_pkg::pio_axi_rsp_s axi_rsp, // Bus answers.
  input wire pio_pkg::pio_pins_s pins_i, // Pin levels.
  input wire pio_pkg::pio_pins_s pins_o, // Pin outputs.
  input wire pio_pkg::pio_pins_s pins_oe, // Pin enables.
  input wire pio_pkg::pio_pins_s pullup_en, // Pullups.
  input wire logic [2:0] led_drive, // LED drive.
  input wire logic dp_pullup_en, // Data-plus pullup.
  input wire logic [7:0] key_wake_inputs // Key inputs.
);
  import pio_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_aw_w_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence s_ar_taken;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  chk_write_answer: assert property (s_aw_w_taken |-> ##[1:2] axi_rsp.bvalid)
    else $error("write not answered");
  chk_read_answer: assert property (s_ar_taken |=> axi_rsp.rvalid)
    else $error("read not answered");
  chk_read_refused: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read taken while answer pending");
  chk_upper_zero: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_err_data: assert property (axi_rsp.rvalid && axi_rsp.rresp == `PIO_RESP_SLVERR |-> axi_rsp.rdata == 32'h0)
    else $error("error read carries data");
  chk_oe_reset: assert property ($rose(aresetn) |-> {pins_oe[28:8], pins_oe[6:0]} == 28'h0)
    else $error("drive enables not cleared by reset");
  chk_a7_clear: assert property (power_on_rst |=> !pins_oe.a[7])
    else $error("port A bit 7 enable not cleared");
  chk_key_pullup: assert property ((key_wake_inputs & ~pullup_en.a) == 8'h0)
    else $error("key input without pullup");
  chk_oe_by_write: assert property ($changed(pins_oe) |-> $rose(axi_rsp.bvalid) || $past(power_on_rst))
    else $error("drive enable changed without a write");
endmodule : pio_port_bank_checker
bind pio_port_bank pio_port_bank_checker pio_port_bank_checker_inst (.aclk, .aresetn, .power_on_rst, .axi_req,
  .axi_rsp, .pins_i, .pins_o, .pins_oe, .pullup_en, .led_drive, .dp_pullup_en, .key_wake_inputs);

// File: tb_top.sv
// Self-checking testbench for the parallel I/O port bank.
`timescale 1ns/1ps
`include "pio_params.svh"
module tb_top;
  import pio_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic power_on_rst = 1'b1;
  pio_axi_req_s req = '0;
  pio_axi_rsp_s rsp;
  pio_pins_s pins_i, pins_o, pins_oe, pullup_en;
  pio_pins_s ext = '0;
  logic [2:0] led_drive;
  logic dp_pullup_en;
  logic [7:0] key_wake_inputs;
  logic [31:0] rd;
  logic [1:0] rs;
  int num_errors = 0;
  int checks_done = 0;
  logic [7:0] idx_tab [9] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h09, 8'h1A, 8'h1B, 8'h3E, 8'h17};
  logic [7:0] mask_tab [9] = '{8'hFF, 8'h23, 8'h0F, 8'hFF, 8'hFC, 8'h23, 8'h3F, 8'h23, 8'hFF};
  logic [7:0] dat_tab [4] = '{8'h01, 8'h02, 8'h03, 8'h08};
  logic [7:0] dmask_tab [4] = '{8'h23, 8'h0F, 8'hFF, 8'hFC};
  always #2 aclk = ~aclk;
  pio_port_bank pio_port_bank_inst (.aclk, .aresetn, .power_on_rst, .axi_req(req), .axi_rsp(rsp), .pins_i,
    .pins_o, .pins_oe, .pullup_en, .led_drive, .dp_pullup_en, .key_wake_inputs);
  pio_pins_model pio_pins_model_inst (.pins_o, .pins_oe, .pullup_en, .ext, .pins_i);
  task automatic give_verdict();
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic axw(input logic [7:0] idx, input logic [7:0] dat, input logic [3:0] strb = 4'hF);
    req.awaddr <= {2'h0, idx, 2'h0};
    req.wdata <= {24'h0, dat};
    req.wstrb <= strb;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (rsp.awready === 1'b1)
        req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1)
        req.wvalid <= 1'b0;
      rs = rsp.bresp;
      if (rsp.bvalid === 1'b1)
        return;
    end
    num_errors++;
    give_verdict();
  endtask : axw
  task automatic axr(input logic [7:0] idx);
    req.araddr <= {2'h0, idx, 2'h0};
    req.arvalid <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (rsp.arready === 1'b1)
        req.arvalid <= 1'b0;
      rd = rsp.rdata;
      rs = rsp.rresp;
      if (rsp.rvalid === 1'b1)
        return;
    end
    num_errors++;
    give_verdict();
  endtask : axr
  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    axr(idx);
    cmp(nm, {24'h0, exp}, rd);
    cmp("read resp", `PIO_RESP_OKAY, rs);
  endtask : rdchk
  initial
  begin
    req.bready <= 1'b1;
    req.rready <= 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    power_on_rst <= 1'b0;
    foreach (idx_tab[i])
      rdchk("reset value", idx_tab[i], 8'h00);
    foreach (idx_tab[i])
    begin
      axw(idx_tab[i], 8'hFF);
      rdchk("implemented bits", idx_tab[i], mask_tab[i]);
    end
    foreach (dat_tab[i])
    begin
      axw(dat_tab[i], 8'hFF);
      rdchk("output latch read", dat_tab[i], dmask_tab[i]);
    end
    cmp("outputs B to E", {6'h3F, 8'hFF, 4'hF, 3'h7}, pins_o[28:8]);
    axw(8'h3E, 8'h00, 4'hE);
    cmp("lane write resp", `PIO_RESP_OKAY, rs);
    rdchk("write without lane 0", 8'h3E, 8'h23);
    cmp("drive enables", {6'h3F, 8'hFF, 4'hF, 3'h7, 8'hFF}, pins_oe);
    cmp("led drive", 3'h7, led_drive);
    cmp("pullups", {1'b1, 2'h3, 8'h8C, 4'h0, 3'h7, 8'hFF}, {dp_pullup_en, pullup_en[24:0]});
    axw(8'h04, 8'h0F);
    axw(8'h17, 8'h30);
    axw(8'h00, 8'h5A);
    ext.a <= 8'hA5;
    repeat (3) @(posedge aclk);
    rdchk("mixed port A read", 8'h00, 8'hBA);
    cmp("key inputs", 8'h30, key_wake_inputs);
    cmp("key pullups", 8'h30, pullup_en.a);
    cmp("port A outputs", 8'h5A, pins_o.a);
    axw(8'h04, 8'hFF);
    rdchk("port A latch read", 8'h00, 8'h5A);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp("port A enables after reset", 8'h80, pins_oe.a);
    cmp("other enables after reset", 28'h0, {pins_oe[28:8], pins_oe.a[6:0]});
    cmp("port A latch after reset", 8'h5A, pins_o.a);
    cmp("other latches after reset", {6'h3F, 8'hFF, 4'hF, 3'h7}, pins_o[28:8]);
    power_on_rst <= 1'b1;
    @(posedge aclk);
    power_on_rst <= 1'b0;
    @(posedge aclk);
    cmp("port A enables after power-on", 8'h00, pins_oe.a);
    axw(8'h20, 8'h55);
    cmp("unmapped write resp", `PIO_RESP_SLVERR, rs);
    axr(8'h20);
    cmp("unmapped read data", 32'h0, rd);
    cmp("unmapped read resp", `PIO_RESP_SLVERR, rs);
    give_verdict();
  end
endmodule : tb_top
